// *** dtc_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the dual timer
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_ADDR_W        4
`define DTC_OFF_SYSCFG    4'h0
`define DTC_OFF_TIMER_MODE_CONTROL      4'h1
`define DTC_OFF_CTRL      4'h2
`define DTC_OFF_CL0       4'h3
`define DTC_OFF_CH0       4'h4
`define DTC_OFF_CL1       4'h5
`define DTC_OFF_CH1       4'h6
`define DTC_OFF_RL0       4'h7
`define DTC_OFF_RH0       4'h8
`define DTC_OFF_RL1       4'h9
`define DTC_OFF_RH1       4'hA
`define DTC_OFF_IRQ_STAT  4'hB
`define DTC_OFF_IRQ_MASK  4'hC
`define DTC_SYSCFG_PS_LSB 2
`define DTC_TIMER_MODE_CONTROL_GATE     3
`define DTC_TIMER_MODE_CONTROL_CT       2
`define DTC_CTRL_OF1      7
`define DTC_CTRL_RUN1     6
`define DTC_CTRL_OF0      5
`define DTC_CTRL_RUN0     4
`define DTC_RST_SYSCFG    8'h00
`define DTC_RST_TIMER_MODE_CONTROL      8'h00
`define DTC_SAMPLE_OSC    2
`endif

// *** dtc_dual_timer.sv ***
// Two 16-bit timer/counters with modes, gating, prescaler and interrupt
// Notes on behaviour
// - Function select picks tick or count pin
// - Two mode bits select four modes
// - Gating: run only while gate pin high
// - No gating: run whenever run bit set
// - Tick is oscillator over 4, 16, 64
// - Each timer has high and low reload registers
// - Mode 00 overflow sets flag, reloads both
// - Mode 10 low reload from low register
// - Mode 01 wraps without reload
// - Mode 00 period is 65536 minus reload
// - Count pins sampled each two cycles, falling edge
// - Flag cleared by acknowledge or software
// - Mode 10 reload leaves high byte alone
// - Split mode: high byte uses timer 1 controls
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"
module dtc_dual_timer (
  input  wire logic                   sys_clk,      // 40 MHz clock
  input  wire logic                   reset_n,      // Async reset, active low
  input  wire logic [`DTC_ADDR_W-1:0] reg_addr,     // Register address
  input  wire logic [7:0]             reg_wdata,    // Write data
  input  wire logic                   reg_wr,       // Write strobe
  input  wire logic                   reg_rd,       // Read strobe
  output logic      [7:0]             reg_rdata,    // Read data, cycle after strobe
  input  wire logic [1:0]             count_input_pin,   // External count pins
  input  wire logic [1:0]             external_gate_pin, // External gate pins
  input  wire logic [1:0]             vector_ack,   // Pulse: interrupt vectored per timer
  output logic      [1:0]             overflow_flag,// Overflow flags
  output logic                        irq           // Level interrupt
);
  typedef struct packed {
    logic [7:0]       syscfg;
    logic [7:0]       timer_mode_control;
    logic [1:0]       run;
    logic [1:0]       ovf;
    logic [1:0][7:0]  cl;
    logic [1:0][7:0]  ch;
    logic [1:0][7:0]  rl;
    logic [1:0][7:0]  rh;
    logic [1:0]       ist;
    logic [1:0]       imask;
    logic [1:0]       cp_s1;
    logic [1:0]       cp_s2;
    logic [1:0]       cp_last;
    logic [1:0]       gp_s1;
    logic [1:0]       gp_s2;
    logic [7:0]       rdata;
  } dtc_st_t;
  dtc_st_t st_ff;
  dtc_st_t nxt_st;

  dtc_tick_if tk ();

  dtc_prescaler u_ps (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tk      (tk)
  );

  assign tk.ps_sel = st_ff.syscfg[`DTC_SYSCFG_PS_LSB +: 2];

  // Per-timer config field from the mode register
  function automatic logic [3:0] cfg_of(input logic [7:0] tm, input int n);
    cfg_of = (n == 1) ? tm[7:4] : tm[3:0];
  endfunction : cfg_of

  // Two-bit mode field of one timer
  function automatic logic [1:0] mode_of(input logic [7:0] tm, input int n);
    mode_of = (n == 1) ? tm[5:4] : tm[1:0];
  endfunction : mode_of

  logic [1:0] fall;
  logic [1:0] adv;
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      logic [3:0] c;
      c = cfg_of(st_ff.timer_mode_control, n);
      // Falling edge seen by sampled pin compared to previous sample
      fall[n] = tk.sample && st_ff.cp_last[n] && !st_ff.cp_s2[n];
      // Increment source and gating
      adv[n] = st_ff.run[n] && (!c[`DTC_TIMER_MODE_CONTROL_GATE] || st_ff.gp_s2[n])
               && (c[`DTC_TIMER_MODE_CONTROL_CT] ? fall[n] : tk.tick);
    end
  end

  // Next state: bus writes, counting, flags
  always_comb begin
    logic [1:0]  hit;
    logic [16:0] sum;
    logic [8:0]  s8;
    logic [8:0]  h8;
    dtc_pkg::dtc_mode_t m;
    logic [3:0]  c0;
    hit    = '0;
    sum    = '0;
    s8     = '0;
    h8     = '0;
    m      = dtc_pkg::DTC_M_RELOAD16;
    c0     = cfg_of(st_ff.timer_mode_control, 0);
    nxt_st = st_ff;
    nxt_st.cp_s1   = count_input_pin;
    nxt_st.cp_s2   = st_ff.cp_s1;
    nxt_st.gp_s1   = external_gate_pin;
    nxt_st.gp_s2   = st_ff.gp_s1;
    if (tk.sample) begin
      nxt_st.cp_last = st_ff.cp_s2;
    end
    // Software writes
    if (reg_wr) begin
      unique case (reg_addr)
        `DTC_OFF_SYSCFG:   nxt_st.syscfg = reg_wdata;
        `DTC_OFF_TIMER_MODE_CONTROL:     nxt_st.timer_mode_control   = reg_wdata;
        `DTC_OFF_CTRL: begin
          nxt_st.run = {reg_wdata[`DTC_CTRL_RUN1], reg_wdata[`DTC_CTRL_RUN0]};
          nxt_st.ovf = {reg_wdata[`DTC_CTRL_OF1], reg_wdata[`DTC_CTRL_OF0]};
        end
        `DTC_OFF_CL0:      nxt_st.cl[0] = reg_wdata;
        `DTC_OFF_CH0:      nxt_st.ch[0] = reg_wdata;
        `DTC_OFF_CL1:      nxt_st.cl[1] = reg_wdata;
        `DTC_OFF_CH1:      nxt_st.ch[1] = reg_wdata;
        `DTC_OFF_RL0:      nxt_st.rl[0] = reg_wdata;
        `DTC_OFF_RH0:      nxt_st.rh[0] = reg_wdata;
        `DTC_OFF_RL1:      nxt_st.rl[1] = reg_wdata;
        `DTC_OFF_RH1:      nxt_st.rh[1] = reg_wdata;
        `DTC_OFF_IRQ_STAT: nxt_st.ist   = st_ff.ist & ~reg_wdata[1:0];
        `DTC_OFF_IRQ_MASK: nxt_st.imask = reg_wdata[1:0];
        default: ;
      endcase
    end
    // Hardware acknowledge clears the flag
    nxt_st.ovf = nxt_st.ovf & ~vector_ack;
    // Counting, per timer
    for (int n = 0; n < 2; n++) begin
      m = dtc_pkg::dtc_mode_t'(mode_of(st_ff.timer_mode_control, n));
      if (adv[n]) begin
        unique case (m)
          dtc_pkg::DTC_M_RELOAD16: begin
            sum = {1'b0, st_ff.ch[n], st_ff.cl[n]} + 17'h00001;
            if (sum[16]) begin
              nxt_st.ch[n] = st_ff.rh[n];
              nxt_st.cl[n] = st_ff.rl[n];
              hit[n] = 1'b1;
            end else begin
              {nxt_st.ch[n], nxt_st.cl[n]} = sum[15:0];
            end
          end
          dtc_pkg::DTC_M_FREE16: begin
            sum = {1'b0, st_ff.ch[n], st_ff.cl[n]} + 17'h00001;
            {nxt_st.ch[n], nxt_st.cl[n]} = sum[15:0];
            hit[n] = sum[16];
          end
          dtc_pkg::DTC_M_RELOAD8: begin
            s8 = {1'b0, st_ff.cl[n]} + 9'h001;
            nxt_st.cl[n] = s8[8] ? st_ff.rl[n] : s8[7:0];
            hit[n] = s8[8];
          end
          dtc_pkg::DTC_M_SPLIT8: begin
            if (n == 0) begin
              s8 = {1'b0, st_ff.cl[0]} + 9'h001;
              nxt_st.cl[0] = s8[7:0];
              hit[0] = s8[8];
            end
          end
        endcase
      end
    end
    // Split mode high byte: timer only, driven by timer 1 run bit and flag
    if (c0[1:0] == 2'h3) begin
      hit[1] = 1'b0;                                                // High byte owns timer 1 flag
      if (st_ff.run[1] && tk.tick) begin
        h8 = {1'b0, st_ff.ch[0]} + 9'h001;
        nxt_st.ch[0] = h8[7:0];
        hit[1] = h8[8];
      end
    end
    // Set wins over any clear in the same cycle
    nxt_st.ovf = nxt_st.ovf | hit;
    nxt_st.ist = nxt_st.ist | hit;
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `DTC_OFF_SYSCFG:   nxt_st.rdata = st_ff.syscfg;
        `DTC_OFF_TIMER_MODE_CONTROL:     nxt_st.rdata = st_ff.timer_mode_control;
        `DTC_OFF_CTRL:     nxt_st.rdata = {st_ff.ovf[1], st_ff.run[1], st_ff.ovf[0], st_ff.run[0], 4'h0};
        `DTC_OFF_CL0:      nxt_st.rdata = st_ff.cl[0];
        `DTC_OFF_CH0:      nxt_st.rdata = st_ff.ch[0];
        `DTC_OFF_CL1:      nxt_st.rdata = st_ff.cl[1];
        `DTC_OFF_CH1:      nxt_st.rdata = st_ff.ch[1];
        `DTC_OFF_RL0:      nxt_st.rdata = st_ff.rl[0];
        `DTC_OFF_RH0:      nxt_st.rdata = st_ff.rh[0];
        `DTC_OFF_RL1:      nxt_st.rdata = st_ff.rl[1];
        `DTC_OFF_RH1:      nxt_st.rdata = st_ff.rh[1];
        `DTC_OFF_IRQ_STAT: nxt_st.rdata = {6'h00, st_ff.ist};
        `DTC_OFF_IRQ_MASK: nxt_st.rdata = {6'h00, st_ff.imask};
        default:           nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff        <= '0;
      st_ff.syscfg <= `DTC_RST_SYSCFG;
      st_ff.timer_mode_control   <= `DTC_RST_TIMER_MODE_CONTROL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata     = st_ff.rdata;
  assign overflow_flag = st_ff.ovf;
  assign irq           = |(st_ff.ist & st_ff.imask);

  // Reload and wrap on overflow
  AST_RELOAD16: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[0] && mode_of(st_ff.timer_mode_control, 0) == 2'h0 && {st_ff.ch[0], st_ff.cl[0]} == 16'hFFFF && !reg_wr)
    |=> ({st_ff.ch[0], st_ff.cl[0]} == $past({st_ff.rh[0], st_ff.rl[0]}) && overflow_flag[0]))
    else $error("reload or flag missing on 16-bit overflow");
  AST_RELOAD16_T1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[1] && mode_of(st_ff.timer_mode_control, 1) == 2'h0 && {st_ff.ch[1], st_ff.cl[1]} == 16'hFFFF && !reg_wr)
    |=> ({st_ff.ch[1], st_ff.cl[1]} == $past({st_ff.rh[1], st_ff.rl[1]}) && overflow_flag[1]))
    else $error("timer 1 reload or flag missing on 16-bit overflow");
  AST_FREE16_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[0] && mode_of(st_ff.timer_mode_control, 0) == 2'h1 && {st_ff.ch[0], st_ff.cl[0]} == 16'hFFFF && !reg_wr)
    |=> ({st_ff.ch[0], st_ff.cl[0]} == 16'h0000 && overflow_flag[0]))
    else $error("free mode did not wrap to zero");
  AST_RELOAD8: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[0] && mode_of(st_ff.timer_mode_control, 0) == 2'h2 && st_ff.cl[0] == 8'hFF && !reg_wr)
    |=> (st_ff.cl[0] == $past(st_ff.rl[0]) && st_ff.ch[0] == $past(st_ff.ch[0])))
    else $error("8-bit reload wrong or high byte changed");
  AST_RELOAD8_T1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[1] && mode_of(st_ff.timer_mode_control, 1) == 2'h2 && st_ff.cl[1] == 8'hFF && !reg_wr)
    |=> (st_ff.cl[1] == $past(st_ff.rl[1]) && st_ff.ch[1] == $past(st_ff.ch[1])))
    else $error("timer 1 8-bit reload wrong or high byte changed");

  // Gating, increment source and stopped timers
  AST_HOLD_STOPPED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!st_ff.run[1] && !reg_wr) |=> $stable(st_ff.cl[1]))
    else $error("stopped timer moved");
  AST_GATE_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_ff.timer_mode_control[`DTC_TIMER_MODE_CONTROL_GATE] && !st_ff.gp_s2[0]) |-> !adv[0])
    else $error("gated timer advanced with gate low");
  AST_GATE_LOW_T1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_ff.timer_mode_control[4 + `DTC_TIMER_MODE_CONTROL_GATE] && !st_ff.gp_s2[1]) |-> !adv[1])
    else $error("gated timer 1 advanced with gate low");
  AST_FREE_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_ff.run[0] && st_ff.gp_s2[0] && !st_ff.timer_mode_control[`DTC_TIMER_MODE_CONTROL_CT] && tk.tick
     && mode_of(st_ff.timer_mode_control, 0) == 2'h1 && !reg_wr)
    |=> ({st_ff.ch[0], st_ff.cl[0]} == $past({st_ff.ch[0], st_ff.cl[0]}) + 16'h0001))
    else $error("running timer missed a tick");
  AST_TICK_SRC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[0] && !st_ff.timer_mode_control[`DTC_TIMER_MODE_CONTROL_CT]) |-> tk.tick)
    else $error("timer advanced without tick");
  AST_TICK_SRC_T1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[1] && !st_ff.timer_mode_control[4 + `DTC_TIMER_MODE_CONTROL_CT]) |-> tk.tick)
    else $error("timer 1 advanced without tick");
  AST_COUNT_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (adv[1] && st_ff.timer_mode_control[4 + `DTC_TIMER_MODE_CONTROL_CT]) |-> (st_ff.cp_last[1] && !st_ff.cp_s2[1]))
    else $error("counter advanced without falling edge");

  // Flags and readback
  AST_ACK_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (vector_ack[0] && !adv[0] && !reg_wr && mode_of(st_ff.timer_mode_control, 0) != 2'h3) |=> !overflow_flag[0])
    else $error("acknowledge did not clear flag");
  AST_READ_LAT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `DTC_OFF_TIMER_MODE_CONTROL && !reg_wr) |=> reg_rdata == $past(st_ff.timer_mode_control))
    else $error("mode register readback wrong");

  // Split mode and timer 1 hold
  AST_SPLIT_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_of(st_ff.timer_mode_control, 0) == 2'h3 && !st_ff.run[1] && !reg_wr) |=> $stable(st_ff.ch[0]))
    else $error("split high byte ran without timer 1 run bit");
  AST_SPLIT_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_of(st_ff.timer_mode_control, 0) == 2'h3 && !st_ff.run[0] && !reg_wr) |=> $stable(st_ff.cl[0]))
    else $error("split low byte ran without timer 0 run bit");
  AST_SPLIT_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_of(st_ff.timer_mode_control, 0) == 2'h3 && st_ff.run[1] && tk.tick && st_ff.ch[0] == 8'hFF)
    |=> (st_ff.ch[0] == 8'h00 && overflow_flag[1]))
    else $error("split high byte overflow did not set timer 1 flag");
  AST_HOLD_MODE3: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_of(st_ff.timer_mode_control, 1) == 2'h3 && !reg_wr) |=> $stable({st_ff.ch[1], st_ff.cl[1]}))
    else $error("timer 1 moved in mode 3");

  // Main scenarios reached
  COV_OVF0: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(overflow_flag[0]));
  COV_SPLIT: cover property (@(posedge sys_clk) disable iff (!reset_n)
    mode_of(st_ff.timer_mode_control, 0) == 2'h3 && $rose(overflow_flag[1]));
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(irq));
  COV_COUNT_PIN: cover property (@(posedge sys_clk) disable iff (!reset_n) adv[1] && fall[1]);
  COV_RELOAD8: cover property (@(posedge sys_clk) disable iff (!reset_n)
    adv[0] && mode_of(st_ff.timer_mode_control, 0) == 2'h2 && st_ff.cl[0] == 8'hFF);
endmodule : dtc_dual_timer
`default_nettype wire

// *** dtc_pin_model.sv ***
// Model of the external count and gate pins that face the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic       sys_clk,           // Oscillator clock
  output var  logic [1:0] count_input_pin,   // Count pins, idle high
  output var  logic [1:0] external_gate_pin  // Gate pins, low at start
);
  int hold_cyc;  // Cycles each pin level stands; raise it for a slow source

  // Idle levels from time zero
  initial begin
    count_input_pin   = 2'h3;
    external_gate_pin = 2'h0;
    hold_cyc          = 2;
  end

  // Falling-edge events, each level held at least two oscillator cycles
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_input_pin[idx] <= 1'h0;
      repeat (hold_cyc) @(posedge sys_clk);
      count_input_pin[idx] <= 1'h1;
      repeat (hold_cyc) @(posedge sys_clk);
    end
  endtask : pulse

  // Gate level change just after an edge
  task automatic gate(input int idx, input logic lvl);
    @(posedge sys_clk);
    external_gate_pin[idx] <= lvl;
  endtask : gate
endmodule : dtc_pin_model
`default_nettype wire

// *** dtc_pkg.sv ***
// Types shared by the dual timer design
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_M_RELOAD16,
    DTC_M_FREE16,
    DTC_M_RELOAD8,
    DTC_M_SPLIT8
  } dtc_mode_t;
endpackage : dtc_pkg

// *** dtc_prescaler.sv ***
// Shared prescaler producing the timer tick and the pin sample enable
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"
module dtc_prescaler (
  input  wire logic   sys_clk,  // System clock
  input  wire logic   reset_n,  // Async reset, active low
  dtc_tick_if.src     tk        // Tick and sample enables
);
  typedef struct packed {
    logic [5:0] div;
    logic       tick;
    logic       sample;
  } dtc_ps_st_t;
  dtc_ps_st_t st_ff;
  dtc_ps_st_t nxt_st;

  // Free running divider; tick on the last count of the selected ratio
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.div    = st_ff.div + 6'h01;
    nxt_st.sample = (st_ff.div[0] == 1'b1);
    unique case (tk.ps_sel)
      2'h1:    nxt_st.tick = (st_ff.div[3:0] == 4'hF);
      2'h2:    nxt_st.tick = (st_ff.div == 6'h3F);
      default: nxt_st.tick = (st_ff.div[1:0] == 2'h3);
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tk.tick   = st_ff.tick;
  assign tk.sample = st_ff.sample;

  AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tk.tick && tk.ps_sel == 2'h0 && $stable(tk.ps_sel)) |-> ##1 !tk.tick [*3])
    else $error("tick came too soon at divide by four");
  AST_SAMPLE_HALF: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tk.sample |=> !tk.sample)
    else $error("sample enable not every two cycles");
endmodule : dtc_prescaler
`default_nettype wire

// *** dtc_tick_if.sv ***
// Carries the shared timer tick and pin sample enable between modules
`timescale 1ns/1ps
`default_nettype none
interface dtc_tick_if;
  logic       tick;
  logic       sample;
  logic [1:0] ps_sel;
  modport src (input ps_sel, output tick, output sample);
  modport dst (output ps_sel, input tick, input sample);
endinterface : dtc_tick_if
`default_nettype wire

// *** test_dual_timer_counter_modes.sv ***
// Self-checking bench for the dual timer: period rows, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"
module test_dual_timer_counter_modes;
  typedef struct { int t; logic [1:0] ps; logic [1:0] md; logic [7:0] rh; logic [7:0] rl; } dtc_row_t;
  logic                   sys_clk    = 1'h0;
  logic                   reset_n    = 1'h0;
  logic [`DTC_ADDR_W-1:0] reg_addr   = 4'h0;
  logic [7:0]             reg_wdata  = 8'h00;
  logic                   reg_wr     = 1'h0;
  logic                   reg_rd     = 1'h0;
  logic [1:0]             vector_ack = 2'h0;
  logic [7:0]             reg_rdata, rd_v;
  logic [1:0]             count_input_pin, external_gate_pin, overflow_flag;
  logic                   irq;
  int                     err_total  = 0;
  int                     n_checks   = 0;
  int                     cyc        = 0;
  int                     r, n, span, t_a, t_b, a;
  dtc_row_t               row;
  dtc_row_t               rows [6] = '{'{0, 2'h0, 2'h0, 8'hFF, 8'hF0}, '{0, 2'h1, 2'h0, 8'hFF, 8'hF0},
                                       '{0, 2'h2, 2'h0, 8'hFF, 8'hF0}, '{1, 2'h0, 2'h0, 8'hFF, 8'hE0},
                                       '{0, 2'h0, 2'h2, 8'h12, 8'hF0}, '{1, 2'h1, 2'h2, 8'h12, 8'hC0}};

  dtc_dual_timer dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_input_pin(count_input_pin),
    .external_gate_pin(external_gate_pin), .vector_ack(vector_ack), .overflow_flag(overflow_flag), .irq(irq));
  dtc_pin_model pins (.sys_clk(sys_clk), .count_input_pin(count_input_pin), .external_gate_pin(external_gate_pin));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Cycle count and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  // Counts and verdict
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // One-cycle register write; strobe released on the next edge
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] ad, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
    chk(nm, e, rd_v);
  endtask : rdchk

  task automatic wait_flag(input int idx, input int lim, output int t);
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if (overflow_flag[idx] === 1'h1) break;
    end
    t = cyc;
    chk("overflow flag", 1, overflow_flag[idx]);
  endtask : wait_flag

  task automatic ack(input logic [1:0] m);
    @(posedge sys_clk);
    vector_ack <= m;
    @(posedge sys_clk);
    vector_ack <= 2'h0;
  endtask : ack

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    for (r = 0; r < 6; r++) begin
      row  = rows[r];
      n    = (row.ps == 2'h1) ? 16 : (row.ps == 2'h2) ? 64 : 4;
      span = (row.md == 2'h2) ? 256 - row.rl : 65536 - {row.rh, row.rl};
      wr(`DTC_OFF_CTRL, 8'h00);
      wr(`DTC_OFF_SYSCFG, {4'h0, row.ps, 2'h0});
      wr(`DTC_OFF_TIMER_MODE_CONTROL, {6'h00, row.md} << (4 * row.t));
      wr(`DTC_OFF_RL0 + 4'(2 * row.t), row.rl);
      wr(`DTC_OFF_RH0 + 4'(2 * row.t), row.rh);
      rdchk(`DTC_OFF_RL0 + 4'(2 * row.t), row.rl, "reload low");
      wr(`DTC_OFF_CL0 + 4'(2 * row.t), 8'hFF);
      wr(`DTC_OFF_CH0 + 4'(2 * row.t), 8'hFF);
      wr(`DTC_OFF_CTRL, 8'h10 << (2 * row.t));
      wait_flag(row.t, 100, t_a);
      ack(2'h1 << row.t);
      #1 chk("flag after ack", 0, overflow_flag[row.t]);
      wait_flag(row.t, 2 * n * span, t_b);
      chk("overflow period", n * span, t_b - t_a);
      rdchk(`DTC_OFF_CH0 + 4'(2 * row.t), 8'hFF, "high byte");
      $display("Row %0d done", r);
    end
    // Free-running 16-bit wrap keeps the reload registers out
    wr(`DTC_OFF_CTRL, 8'h00);
    wr(`DTC_OFF_SYSCFG, 8'h00);
    wr(`DTC_OFF_TIMER_MODE_CONTROL, 8'h09);
    wr(`DTC_OFF_RH0, 8'hAA);
    wr(`DTC_OFF_RL0, 8'hAA);
    wr(`DTC_OFF_CL0, 8'hFE);
    wr(`DTC_OFF_CH0, 8'hFF);
    wr(`DTC_OFF_CTRL, 8'h10);
    repeat (8) @(posedge sys_clk);
    rdchk(`DTC_OFF_CL0, 8'hFE, "gated timer with gate low");
    pins.gate(0, 1'h1);
    wait_flag(0, 100, t_a);
    rdchk(`DTC_OFF_CH0, 8'h00, "wrapped high byte");
    $display("Free-run test done");
    // Split mode: high byte of timer 0 runs on timer 1 run bit and flag
    wr(`DTC_OFF_CTRL, 8'h00);
    wr(`DTC_OFF_TIMER_MODE_CONTROL, 8'h33);
    wr(`DTC_OFF_CL1, 8'h5A);
    wr(`DTC_OFF_CL0, 8'h00);
    wr(`DTC_OFF_CH0, 8'hFF);
    wr(`DTC_OFF_CTRL, 8'h40);
    wait_flag(1, 100, t_a);
    chk("split low flag", 0, overflow_flag[0]);
    rdchk(`DTC_OFF_CL0, 8'h00, "split low byte");
    rdchk(`DTC_OFF_CL1, 8'h5A, "timer 1 held in mode 3");
    $display("Split test done");
    // Timer 1 counts pin events, first gated, then ungated
    wr(`DTC_OFF_CTRL, 8'h00);
    wr(`DTC_OFF_TIMER_MODE_CONTROL, 8'hD0);
    wr(`DTC_OFF_CL1, 8'h00);
    wr(`DTC_OFF_CH1, 8'h00);
    wr(`DTC_OFF_CTRL, 8'h40);
    pins.pulse(1, 3);
    repeat (6) @(posedge sys_clk);
    rdchk(`DTC_OFF_CL1, 8'h00, "count with gate low");
    pins.gate(1, 1'h1);
    pins.hold_cyc = 6;
    pins.pulse(1, 3);
    repeat (6) @(posedge sys_clk);
    rdchk(`DTC_OFF_CL1, 8'h03, "count with gate high");
    wr(`DTC_OFF_TIMER_MODE_CONTROL, 8'h50);
    pins.gate(1, 1'h0);
    pins.hold_cyc = 2;
    pins.pulse(1, 2);
    repeat (6) @(posedge sys_clk);
    rdchk(`DTC_OFF_CL1, 8'h05, "count without gating");
    $display("Counter test done");
    // Interrupt mask, level and write-one-to-clear status
    wr(`DTC_OFF_CTRL, 8'h00);
    wr(`DTC_OFF_IRQ_MASK, 8'h00);
    #1 chk("irq masked", 0, irq);
    wr(`DTC_OFF_IRQ_MASK, 8'h02);
    #1 chk("irq unmasked", 1, irq);
    wr(`DTC_OFF_IRQ_STAT, 8'h03);
    #1 chk("irq cleared", 0, irq);
    rdchk(`DTC_OFF_IRQ_STAT, 8'h00, "irq status");
    $display("Interrupt test done");
    // Unmapped write and read, second reset, then reset values
    wr(4'hF, 8'h5A);
    rdchk(4'hF, 8'h00, "unmapped read");
    @(posedge sys_clk);
    reset_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'h1;
    for (a = 0; a < 13; a++) rdchk(4'(a), 8'h00, "reset value");
    chk("flags after reset", 0, overflow_flag);
    $display("Reset test done");
    print_verdict();
  end
endmodule : test_dual_timer_counter_modes
`default_nettype wire
